//--- hw/iop_pkg.sv
// Constants for the general-purpose I/O port with change notification.
// Assumes a 32-bit AXI4-Lite register bus and a 16-pin port.
package iop_pkg;
   localparam int          NPINS        = 16;
   localparam logic [11:0] OFS_DIR      = 12'h000;
   localparam logic [11:0] OFS_PIN      = 12'h004;
   localparam logic [11:0] OFS_LAT      = 12'h008;
   localparam logic [11:0] OFS_ODS      = 12'h00c;
   localparam logic [11:0] OFS_ANS      = 12'h010;
   localparam logic [11:0] OFS_CIE      = 12'h014;
   localparam logic [11:0] OFS_PUE      = 12'h018;
   localparam logic [11:0] OFS_PDE      = 12'h01c;
   localparam logic [11:0] OFS_CST      = 12'h020;
   localparam logic [15:0] RST_ANS      = 16'hffff;
   localparam logic [15:0] RST_DIR      = 16'hffff;
   localparam logic [15:0] RST_ZERO     = 16'h0000;
   localparam logic [1:0]  RESP_OKAY    = 2'b00;
   localparam logic [1:0]  RESP_SLVERR  = 2'b10;
endpackage : iop_pkg

//--- hw/iop_sync.sv
// Two-flop synchroniser bank for the pin inputs.
// Assumes the pins are asynchronous to core_clk.
`timescale 1ns/1ps
module iop_sync (
   // Clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     sys_rst,
   // Data
   input  wire logic [iop_pkg::NPINS-1:0] async_in,
   output logic      [iop_pkg::NPINS-1:0] sync_out
);
   typedef struct packed {
      logic [iop_pkg::NPINS-1:0] s1;
      logic [iop_pkg::NPINS-1:0] s2;
   } iop_sync_s;
   iop_sync_s st_reg;
   iop_sync_s st_next;

   always_comb begin
      st_next.s1 = async_in;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sync_out = st_reg.s2;
endmodule : iop_sync

//--- hw/iop_port.sv
// GPIO port: direction, latch, open drain, analog select, pulls, change notice.
// Assumes an AXI4-Lite master on core_clk and a pad ring resolving pins.
`timescale 1ns/1ps
module iop_port (
   // Clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     sys_rst,
   // AXI4-Lite write
   input  wire logic [11:0]              s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   // AXI4-Lite read
   input  wire logic [11:0]              s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   // Pads
   input  wire logic [iop_pkg::NPINS-1:0] pin_in,
   output logic      [iop_pkg::NPINS-1:0] pin_out,
   output logic      [iop_pkg::NPINS-1:0] pin_oe_n,
   output logic      [iop_pkg::NPINS-1:0] weak_pullup_on,
   output logic      [iop_pkg::NPINS-1:0] weak_pulldown_on,
   output logic      [iop_pkg::NPINS-1:0] analog_mode,
   // Change notice
   output logic                          input_change_notice
);
   localparam int N = iop_pkg::NPINS;

   typedef struct packed {
      logic [N-1:0]  direction_control;
      logic [N-1:0]  output_latch;
      logic [N-1:0]  open_drain_select;
      logic [N-1:0]  analog_select;
      logic [N-1:0]  change_irq_enable;
      logic [N-1:0]  weak_pullup_enable;
      logic [N-1:0]  weak_pulldown_enable;
      logic [N-1:0]  captured;
      logic [N-1:0]  state_change_event;
      logic [N-1:0]  pin_out;
      logic [N-1:0]  pin_oe_n;
      logic [N-1:0]  pu;
      logic [N-1:0]  pd;
      logic [N-1:0]  an;
      logic          notice;
      logic          aw_got;
      logic          w_got;
      logic          aw_rdy;
      logic          w_rdy;
      logic          ar_rdy;
      logic [11:0]   awaddr;
      logic [31:0]   wdata;
      logic [3:0]    wstrb;
      logic          bvalid;
      logic [1:0]    bresp;
      logic          rvalid;
      logic [1:0]    rresp;
      logic [31:0]   rdata;
   } iop_port_s;

   iop_port_s    st_reg;
   iop_port_s    st_next;
   logic [N-1:0] pin_sync;
   logic [N-1:0] pin_input_value;
   logic [N-1:0] changed;
   logic [N-1:0] wmask;

   ////////////////////////////////////////////////////////////////////////////
   iop_sync u_sync (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .async_in (pin_in),
      .sync_out (pin_sync)
   );

   // Analog inputs read low; digital buffer is off there
   assign pin_input_value = pin_sync & ~(st_reg.analog_select & st_reg.direction_control);
   // Only pins with their change enable set are watched, outputs included
   assign changed = (pin_input_value ^ st_reg.captured) & st_reg.change_irq_enable;

   // Byte strobes on the low 16 bits only
   assign wmask = {{8{st_reg.wstrb[1]}}, {8{st_reg.wstrb[0]}}};

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_next = st_reg;
      st_next.captured = pin_input_value;
      // Set wins over a same-cycle clear
      st_next.state_change_event = st_reg.state_change_event | changed;

      // Write channel: take address and data in either order
      if (s_axi_awvalid && !st_reg.aw_got) begin
         st_next.aw_got = 1'b1;
         st_next.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_reg.w_got) begin
         st_next.w_got = 1'b1;
         st_next.wdata = s_axi_wdata;
         st_next.wstrb = s_axi_wstrb;
      end
      if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
         st_next.aw_got = 1'b0;
         st_next.w_got  = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp  = iop_pkg::RESP_OKAY;
         case (st_reg.awaddr)
            iop_pkg::OFS_DIR: st_next.direction_control =
               (st_reg.direction_control & ~wmask) | (st_reg.wdata[N-1:0] & wmask);
            iop_pkg::OFS_LAT: st_next.output_latch =
               (st_reg.output_latch & ~wmask) | (st_reg.wdata[N-1:0] & wmask);
            iop_pkg::OFS_ODS: st_next.open_drain_select =
               (st_reg.open_drain_select & ~wmask) | (st_reg.wdata[N-1:0] & wmask);
            iop_pkg::OFS_ANS: st_next.analog_select =
               (st_reg.analog_select & ~wmask) | (st_reg.wdata[N-1:0] & wmask);
            iop_pkg::OFS_CIE: st_next.change_irq_enable =
               (st_reg.change_irq_enable & ~wmask) | (st_reg.wdata[N-1:0] & wmask);
            iop_pkg::OFS_PUE: st_next.weak_pullup_enable =
               (st_reg.weak_pullup_enable & ~wmask) | (st_reg.wdata[N-1:0] & wmask);
            iop_pkg::OFS_PDE: st_next.weak_pulldown_enable =
               (st_reg.weak_pulldown_enable & ~wmask) | (st_reg.wdata[N-1:0] & wmask);
            // Write one to clear; new events still set
            iop_pkg::OFS_CST: st_next.state_change_event =
               (st_reg.state_change_event & ~(st_reg.wdata[N-1:0] & wmask)) | changed;
            iop_pkg::OFS_PIN: begin
            end
            default: st_next.bresp = iop_pkg::RESP_SLVERR;
         endcase
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end

      // Read channel
      if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !st_reg.rvalid) begin
         st_next.rvalid = 1'b1;
         st_next.rresp  = iop_pkg::RESP_OKAY;
         st_next.rdata  = '0;
         case (s_axi_araddr)
            iop_pkg::OFS_DIR: st_next.rdata[N-1:0] = st_reg.direction_control;
            iop_pkg::OFS_PIN: st_next.rdata[N-1:0] = pin_input_value;
            iop_pkg::OFS_LAT: st_next.rdata[N-1:0] = st_reg.output_latch;
            iop_pkg::OFS_ODS: st_next.rdata[N-1:0] = st_reg.open_drain_select;
            iop_pkg::OFS_ANS: st_next.rdata[N-1:0] = st_reg.analog_select;
            iop_pkg::OFS_CIE: st_next.rdata[N-1:0] = st_reg.change_irq_enable;
            iop_pkg::OFS_PUE: st_next.rdata[N-1:0] = st_reg.weak_pullup_enable;
            iop_pkg::OFS_PDE: st_next.rdata[N-1:0] = st_reg.weak_pulldown_enable;
            iop_pkg::OFS_CST: st_next.rdata[N-1:0] = st_reg.state_change_event;
            default:          st_next.rresp = iop_pkg::RESP_SLVERR;
         endcase
      end

      // Pad drive: open drain only ever pulls low
      for (int i = 0; i < N; i++) begin
         if (st_reg.open_drain_select[i]) begin
            st_next.pin_out[i]  = 1'b0;
            st_next.pin_oe_n[i] = st_reg.direction_control[i] | st_reg.output_latch[i];
         end else begin
            st_next.pin_out[i]  = st_reg.output_latch[i];
            st_next.pin_oe_n[i] = st_reg.direction_control[i];
         end
      end
      st_next.pu     = st_reg.weak_pullup_enable;
      st_next.pd     = st_reg.weak_pulldown_enable;
      st_next.an     = st_reg.analog_select;
      st_next.notice = |st_next.state_change_event;
      // Readies registered too, so no output passes through a gate
      st_next.aw_rdy = !st_next.aw_got;
      st_next.w_rdy  = !st_next.w_got;
      st_next.ar_rdy = !st_next.rvalid;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_reg                      <= '0;
         st_reg.direction_control    <= iop_pkg::RST_DIR;
         st_reg.analog_select        <= iop_pkg::RST_ANS;
         st_reg.an                   <= iop_pkg::RST_ANS;
         st_reg.pin_oe_n             <= iop_pkg::RST_DIR;
         st_reg.output_latch         <= iop_pkg::RST_ZERO;
         st_reg.aw_rdy               <= 1'b1;
         st_reg.w_rdy                <= 1'b1;
         st_reg.ar_rdy               <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Writes land in a register before they reach pads, hence the turnaround
   assign s_axi_awready    = st_reg.aw_rdy;
   assign s_axi_wready     = st_reg.w_rdy;
   assign s_axi_bvalid     = st_reg.bvalid;
   assign s_axi_bresp      = st_reg.bresp;
   assign s_axi_arready    = st_reg.ar_rdy;
   assign s_axi_rvalid     = st_reg.rvalid;
   assign s_axi_rresp      = st_reg.rresp;
   assign s_axi_rdata      = st_reg.rdata;
   assign pin_out          = st_reg.pin_out;
   assign pin_oe_n         = st_reg.pin_oe_n;
   assign weak_pullup_on   = st_reg.pu;
   assign weak_pulldown_on = st_reg.pd;
   assign analog_mode      = st_reg.an;
   assign input_change_notice = st_reg.notice;

   ////////////////////////////////////////////////////////////////////////////
   sequence s_pin_flips(int i);
      st_reg.change_irq_enable[i] && (pin_input_value[i] != st_reg.captured[i]);
   endsequence

   a_change_flagged: assert property (@(posedge core_clk) disable iff (sys_rst)
      s_pin_flips(8) |=> st_reg.state_change_event[8])
      else $error("enabled pin change not flagged");
   a_notice_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
      (|changed) |=> input_change_notice)
      else $error("change notice not raised");
   a_disabled_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!st_reg.change_irq_enable[9] && !st_reg.state_change_event[9]
       && !(s_axi_awvalid || st_reg.aw_got)) |=> !st_reg.state_change_event[9])
      else $error("disabled pin set its event");
   a_analog_reads_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
      (st_reg.analog_select[2] && st_reg.direction_control[2]) |-> !pin_input_value[2])
      else $error("analog input read nonzero");
   a_od_never_high: assert property (@(posedge core_clk) disable iff (sys_rst)
      (st_reg.open_drain_select[3] && $stable(st_reg.open_drain_select[3]))
      |=> (pin_oe_n[3] || !pin_out[3]))
      else $error("open drain drove high");
   a_analog_out_drives: assert property (@(posedge core_clk) disable iff (sys_rst)
      (!st_reg.direction_control[4] && !st_reg.open_drain_select[4])
      |=> (!pin_oe_n[4] && pin_out[4] == $past(st_reg.output_latch[4])))
      else $error("output not driven with analog set");
   a_pull_follow: assert property (@(posedge core_clk) disable iff (sys_rst)
      1'b1 |=> (weak_pullup_on == $past(st_reg.weak_pullup_enable)
               && weak_pulldown_on == $past(st_reg.weak_pulldown_enable)))
      else $error("pull enables not forwarded");
   a_reset_analog: assert property (@(posedge core_clk)
      sys_rst |=> (st_reg.analog_select == iop_pkg::RST_ANS))
      else $error("analog select not all ones after reset");
endmodule : iop_port

//--- test/iop_pads.sv
// Pad ring model: resolves each pin from the port driver, an outside source and the pulls.
// Assumes the outside source never fights a pin that the port drives.
`timescale 1ns/1ps
module iop_pads (
   // Clock
   input  wire logic                      core_clk,
   // From the port
   input  wire logic [iop_pkg::NPINS-1:0] pin_out,
   input  wire logic [iop_pkg::NPINS-1:0] pin_oe_n,
   input  wire logic [iop_pkg::NPINS-1:0] weak_pullup_on,
   input  wire logic [iop_pkg::NPINS-1:0] weak_pulldown_on,
   // Outside source
   input  wire logic [iop_pkg::NPINS-1:0] ext_en,
   input  wire logic [iop_pkg::NPINS-1:0] ext_val,
   // Resolved level
   output logic      [iop_pkg::NPINS-1:0] pin_in
);
   logic [iop_pkg::NPINS-1:0] float_reg = 16'h5a5a;
   ////////////////////////////////////////////////////////////////////////////////
   // Undriven pins change every cycle, so a stale level never passes for a real one
   always_ff @(posedge core_clk) begin
      float_reg <= ~float_reg;
   end
   always_comb begin
      for (int i = 0; i < iop_pkg::NPINS; i++) begin
         if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
         else if (ext_en[i]) pin_in[i] = ext_val[i];
         else if (weak_pullup_on[i]) pin_in[i] = 1'b1;
         else if (weak_pulldown_on[i]) pin_in[i] = 1'b0;
         else pin_in[i] = float_reg[i];
      end
   end
endmodule : iop_pads

//--- test/iop_port_tb.sv
// Self-checking bench for the I/O port: AXI4-Lite register traffic plus pad stimulus.
// Assumes the pad model above stands on the pins; one clock, synchronous reset.
`timescale 1ns/1ps
module iop_port_tb;
   logic        core_clk = 1'b0, sys_rst = 1'b1;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  wstrb = 4'h0;
   logic        awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
   logic        arvalid = 0, arready, rvalid, rready = 0;
   logic [1:0]  bresp, rresp;
   logic [15:0] pin_in, pin_out, pin_oe_n, pu, pd, amode;
   logic [15:0] ext_en = 16'hff00, ext_val = 16'hffff;
   logic        notice;
   int          error_cnt = 0, comparisons = 0, n;
   ////////////////////////////////////////////////////////////////////////////////
   always #12.5 core_clk = ~core_clk;
   iop_port uut (.core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .weak_pullup_on(pu), .weak_pulldown_on(pd), .analog_mode(amode),
      .input_change_notice(notice));
   iop_pads pads (.core_clk(core_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .weak_pullup_on(pu), .weak_pulldown_on(pd), .ext_en(ext_en), .ext_val(ext_val),
      .pin_in(pin_in));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic final_report;
      $display("checks %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : final_report
   // Hung handshake ends the run rather than stalling it
   task automatic hung;
      error_cnt++;
      final_report();
   endtask : hung
   task automatic settle(input int c);
      repeat (c) @(posedge core_clk);
      @(negedge core_clk);
   endtask : settle
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      @(posedge core_clk);
      awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (n == 50) hung();
      chk("bresp", {30'h0, bresp}, {30'h0, er});
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge core_clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      if (n == 50) hung();
      chk("rdata", rdata, exp);
      chk("rresp", {30'h0, rresp}, {30'h0, er});
   endtask : rd
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      settle(0);
      chk("analog_mode", {16'h0, amode}, 32'h0000ffff);
      chk("oe_n", {16'h0, pin_oe_n}, 32'h0000ffff);
      chk("notice", {31'h0, notice}, 32'h0);
      rd(iop_pkg::OFS_ANS, 32'h0000ffff, iop_pkg::RESP_OKAY);
      rd(iop_pkg::OFS_DIR, 32'h0000ffff, iop_pkg::RESP_OKAY);
      rd(iop_pkg::OFS_PUE, 32'h0, iop_pkg::RESP_OKAY);
      $display("test reset done");
      // Outputs on the low byte while analog is still selected
      wr(iop_pkg::OFS_LAT, 32'h000000a5, 4'hf, iop_pkg::RESP_OKAY);
      wr(iop_pkg::OFS_DIR, 32'h0000ff00, 4'hf, iop_pkg::RESP_OKAY);
      settle(3);
      chk("oe_n", {16'h0, pin_oe_n}, 32'h0000ff00);
      chk("pin_out", {24'h0, pin_out[7:0]}, 32'h000000a5);
      chk("analog_mode", {16'h0, amode}, 32'h0000ffff);
      rd(iop_pkg::OFS_PIN, 32'h000000a5, iop_pkg::RESP_OKAY);
      $display("test analog output done");
      wr(iop_pkg::OFS_ODS, 32'h000000ff, 4'hf, iop_pkg::RESP_OKAY);
      settle(2);
      chk("oe_n", {16'h0, pin_oe_n}, 32'h0000ffa5);
      chk("pin_out", {24'h0, pin_out[7:0]}, 32'h0);
      wr(iop_pkg::OFS_ODS, 32'h0, 4'hf, iop_pkg::RESP_OKAY);
      $display("test open drain done");
      // Pull-up byte strobe picks the high byte only; pulls kept off the outputs
      wr(iop_pkg::OFS_PUE, 32'h0000ffff, 4'h2, iop_pkg::RESP_OKAY);
      wr(iop_pkg::OFS_PDE, 32'h00000f00, 4'hf, iop_pkg::RESP_OKAY);
      settle(2);
      chk("pullup", {16'h0, pu}, 32'h0000ff00);
      chk("pulldown", {16'h0, pd}, 32'h00000f00);
      rd(iop_pkg::OFS_PUE, 32'h0000ff00, iop_pkg::RESP_OKAY);
      $display("test pulls done");
      wr(iop_pkg::OFS_ANS, 32'h000000ff, 4'hf, iop_pkg::RESP_OKAY);
      settle(3);
      chk("analog_mode", {16'h0, amode}, 32'h000000ff);
      rd(iop_pkg::OFS_PIN, 32'h0000ffa5, iop_pkg::RESP_OKAY);
      $display("test digital input done");
      wr(iop_pkg::OFS_CIE, 32'h00000100, 4'hf, iop_pkg::RESP_OKAY);
      wr(iop_pkg::OFS_CST, 32'h0000ffff, 4'hf, iop_pkg::RESP_OKAY);
      ext_val <= 16'hfdff;
      settle(6);
      chk("notice", {31'h0, notice}, 32'h0);
      rd(iop_pkg::OFS_CST, 32'h0, iop_pkg::RESP_OKAY);
      ext_val <= 16'hfcff;
      settle(6);
      chk("notice", {31'h0, notice}, 32'h1);
      rd(iop_pkg::OFS_CST, 32'h00000100, iop_pkg::RESP_OKAY);
      wr(iop_pkg::OFS_CST, 32'h00000100, 4'hf, iop_pkg::RESP_OKAY);
      settle(2);
      chk("notice", {31'h0, notice}, 32'h0);
      $display("test change notice done");
      wr(12'h024, 32'h0000ffff, 4'hf, iop_pkg::RESP_SLVERR);
      rd(12'h024, 32'h0, iop_pkg::RESP_SLVERR);
      wr(iop_pkg::OFS_PIN, 32'h0, 4'hf, iop_pkg::RESP_OKAY);
      rd(iop_pkg::OFS_PIN, 32'h0000fca5, iop_pkg::RESP_OKAY);
      $display("test bus errors done");
      final_report();
   end
endmodule : iop_port_tb
